//--- test/mcu_instruction_execute_tail_tb_top.sv
/*
 * Self-checking bench for the execute tail: issues each operation through
 * its start handshake and compares strobes, data, flags and skip timing.
 * Assumes the package is compiled first; program memory is modelled here.
 */
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
    $display("unexpected %s: expected %0h seen %0h", nm, e, g); end end

module mcu_instruction_execute_tail_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    // ****************************************************************
    // Stimulus and observed signals
    // ****************************************************************
    logic              clk_sys = 1'b0;            // 20 MHz core clock
    logic              rst_n   = 1'b0;            // Async reset, low active
    logic              start   = 1'b0;            // Issue strobe
    mxt_pkg::mxt_op_t  op      = mxt_pkg::OP_BYTE_SET;
    logic [7:0]        acc = 8'h00, mem = 8'h00, tpl = 8'h00, imm = 8'h00;
    logic [2:0]        bsel    = 3'h0;            // Selected bit
    logic [3:0]        tph     = 4'h0;            // High pointer
    logic [15:0]       rom     = 16'hFFFF;        // Program word bus
    wire               ready, acc_we, mem_we, skip, dummy, done, rom_re;
    wire  [7:0]        acc_wd, mem_wd, thl;
    wire  [3:0]        fwe, fv;
    wire  [11:0]       rom_addr;
    int                err_count = 0;             // Mismatches
    int                checked   = 0;             // Comparisons

    always #25 clk_sys = ~clk_sys;

    mxt_exec i_mxt_exec (.clk_sys_i(clk_sys), .rst_n_i(rst_n), .start_i(start), .op_i(op),
        .acc_i(acc), .mem_rdata_i(mem), .imm_i(imm), .bit_sel_i(bsel),
        .table_pointer_low_i(tpl), .table_pointer_high_i(tph), .rom_data_i(rom),
        .ready_o(ready), .acc_we_o(acc_we), .acc_wdata_o(acc_wd), .mem_we_o(mem_we),
        .mem_wdata_o(mem_wd), .flags_we_o(fwe), .flags_o(fv), .skip_o(skip),
        .dummy_o(dummy), .done_o(done), .rom_re_o(rom_re), .rom_addr_o(rom_addr),
        .table_high_latch_o(thl));

    // ****************************************************************
    // Tasks
    // ****************************************************************
    // Verdict and end of run, shared with the watchdog
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // One operation; c = {acc write, mem write, skip}, f = {mask, values}
    task automatic run(input mxt_pkg::mxt_op_t o, input logic [7:0] a, m,
                       input logic [2:0] b, input logic [7:0] r,
                       input logic [2:0] c, input logic [7:0] f);
        @(posedge clk_sys);
        start <= 1'b1;
        op    <= o;
        acc   <= a;
        mem   <= (o inside {mxt_pkg::OP_SUB_IMM, mxt_pkg::OP_XOR_IMM}) ? ~m : m;
        imm   <= m;
        bsel  <= b;
        @(posedge clk_sys);
        start <= 1'b0;
        mem   <= ~m;  // Stale operand must not matter
        #1;
        `CHK("acc_we", c[2], acc_we)
        `CHK("mem_we", c[1], mem_we)
        if (c[2]) `CHK("acc_wdata", r, acc_wd)
        if (c[1]) `CHK("mem_wdata", r, mem_wd)
        `CHK("flags_we", f[7:4], fwe)
        `CHK("flags", f[3:0], fv & f[7:4])
        `CHK("skip", c[0], skip)
        `CHK("dummy", c[0], dummy)
        `CHK("done", ~c[0], done)
        `CHK("ready", ~c[0], ready)
        if (c[0]) begin
            @(posedge clk_sys);
            #1;
            `CHK("done_after_dummy", 1'b1, done)
            `CHK("dummy_ends", 1'b0, dummy)
        end
    endtask

    // Table read with program word w returned in the data cycle
    task automatic tbl(input mxt_pkg::mxt_op_t o, input logic [3:0] h,
                       input logic [7:0] l, input logic [15:0] w,
                       input logic [11:0] ea);
        @(posedge clk_sys);
        start <= 1'b1;
        op    <= o;
        tph   <= h;
        tpl   <= l;
        @(posedge clk_sys);
        start <= 1'b0;
        #1;
        `CHK("rom_re", 1'b1, rom_re)
        `CHK("rom_addr", ea, rom_addr)
        @(posedge clk_sys);
        rom <= w;
        @(posedge clk_sys);
        rom <= ~w;  // Word no longer held
        #1;
        `CHK("tbl_mem_we", 1'b1, mem_we)
        `CHK("tbl_low", w[7:0], mem_wd)
        `CHK("tbl_high", w[15:8], thl)
        `CHK("tbl_done", 1'b1, done)
    endtask

    // ****************************************************************
    // Watchdog: the sequence needs well under 500 cycles
    // ****************************************************************
    initial begin
        repeat (3000) @(posedge clk_sys);
        err_count++;
        print_verdict();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (12) @(posedge clk_sys);
        `CHK("reset_ready", 1'b1, ready)
        rst_n <= 1'b1;
        run(mxt_pkg::OP_DEC_SKIP_TO_ACCUM, 8'h00, 8'h01, 3'h0, 8'h00, 3'b101, 8'h00);
        run(mxt_pkg::OP_DEC_SKIP_TO_ACCUM, 8'h00, 8'h00, 3'h0, 8'hFF, 3'b100, 8'h00);
        run(mxt_pkg::OP_BYTE_SET, 8'h00, 8'h12, 3'h0, 8'hFF, 3'b010, 8'h00);
        run(mxt_pkg::OP_BIT_SET, 8'h00, 8'h00, 3'h7, 8'h80, 3'b010, 8'h00);
        run(mxt_pkg::OP_BIT_SET, 8'h00, 8'h55, 3'h1, 8'h57, 3'b010, 8'h00);
        run(mxt_pkg::OP_INC_SKIP_IN_MEMORY, 8'h00, 8'hFF, 3'h0, 8'h00, 3'b011, 8'h00);
        run(mxt_pkg::OP_INC_SKIP_TO_ACCUM, 8'h00, 8'hFF, 3'h0, 8'h00, 3'b101, 8'h00);
        run(mxt_pkg::OP_INC_SKIP_TO_ACCUM, 8'h00, 8'h7F, 3'h0, 8'h80, 3'b100, 8'h00);
        run(mxt_pkg::OP_SKIP_IF_BIT_ONE, 8'h00, 8'h08, 3'h3, 8'h00, 3'b001, 8'h00);
        run(mxt_pkg::OP_SKIP_IF_BIT_ONE, 8'h00, 8'h08, 3'h2, 8'h00, 3'b000, 8'h00);
        run(mxt_pkg::OP_SKIP_IF_BIT_CLEAR, 8'h00, 8'hF7, 3'h3, 8'h00, 3'b001, 8'h00);
        run(mxt_pkg::OP_SKIP_IF_BIT_CLEAR, 8'h00, 8'hF7, 3'h0, 8'h00, 3'b000, 8'h00);
        run(mxt_pkg::OP_SKIP_IF_NULL, 8'h00, 8'h00, 3'h0, 8'h00, 3'b001, 8'h00);
        run(mxt_pkg::OP_SKIP_IF_NULL, 8'h00, 8'h01, 3'h0, 8'h00, 3'b000, 8'h00);
        run(mxt_pkg::OP_COPY_AND_SKIP_IF_NULL, 8'h00, 8'h00, 3'h0, 8'h00, 3'b101, 8'h00);
        run(mxt_pkg::OP_COPY_AND_SKIP_IF_NULL, 8'h00, 8'h42, 3'h0, 8'h42, 3'b100, 8'h00);
        run(mxt_pkg::OP_SUB_TO_ACCUM, 8'h05, 8'h07, 3'h0, 8'hFE, 3'b100, 8'hF0);
        run(mxt_pkg::OP_SUBTRACT_INTO_MEMORY, 8'h80, 8'h01, 3'h0, 8'h7F, 3'b010, 8'hF9);
        run(mxt_pkg::OP_SUB_IMM, 8'h33, 8'h33, 3'h0, 8'h00, 3'b100, 8'hF7);
        run(mxt_pkg::OP_NIBBLE_EXCHANGE, 8'h00, 8'hA5, 3'h0, 8'h5A, 3'b010, 8'h00);
        run(mxt_pkg::OP_NIBBLE_EXCHANGE_TO_ACCUM, 8'h00, 8'h3C, 3'h0, 8'hC3, 3'b100, 8'h00);
        run(mxt_pkg::OP_XOR_TO_ACCUM, 8'h5A, 8'hA5, 3'h0, 8'hFF, 3'b100, 8'h40);
        run(mxt_pkg::OP_EXCLUSIVE_OR_INTO_MEMORY, 8'h3C, 8'h3C, 3'h0, 8'h00, 3'b010, 8'h44);
        run(mxt_pkg::OP_XOR_IMM, 8'h0F, 8'hF0, 3'h0, 8'hFF, 3'b100, 8'h40);
        tbl(mxt_pkg::OP_TABLE_FETCH, 4'h3, 8'hA7, 16'hBEEF, 12'h3A7);
        tbl(mxt_pkg::OP_TABLE_FETCH_LAST_PAGE, 4'h3, 8'h5C, 16'h1234, 12'hF5C);
        print_verdict();
    end
endmodule

//--- verilog/mxt_alu.sv
/*
 * Combinational datapath of the execute tail: result byte, destination,
 * flag values with write mask, skip decision and table-op marker.
 * Assumes operands are stable for the cycle in which they are used.
 */
module mxt_alu (
    input  wire mxt_pkg::mxt_op_t    op_i,        // Decoded operation
    input  wire logic [7:0]          acc_i,       // Accumulator
    input  wire logic [7:0]          mem_i,       // Addressed byte
    input  wire logic [7:0]          imm_i,       // Immediate operand
    input  wire logic [2:0]          bit_sel_i,   // Selected bit
    output logic      [7:0]          res_o,       // Result byte
    output logic                     acc_we_o,    // Result to accumulator
    output logic                     mem_we_o,    // Result to memory
    output logic      [3:0]          flags_we_o,  // Flag write mask
    output logic      [3:0]          flags_o,     // Flag values
    output logic                     skip_o,      // Skip next instruction
    output logic                     table_o      // Table read operation
);

    // ****************************************************************
    // Operand and arithmetic terms
    // ****************************************************************
    wire       use_imm = (op_i == mxt_pkg::OP_SUB_IMM) || (op_i == mxt_pkg::OP_XOR_IMM);
    wire [7:0] opnd    = use_imm ? imm_i : mem_i;            // Second operand
    wire [7:0] dec_b   = mem_i - mxt_pkg::ONE_BYTE;           // Byte minus one
    wire [7:0] inc_b   = mem_i + mxt_pkg::ONE_BYTE;           // Byte plus one
    wire [8:0] diff9   = {1'b0, acc_i} - {1'b0, opnd};        // Borrow in bit 8
    wire [4:0] half5   = {1'b0, acc_i[3:0]} - {1'b0, opnd[3:0]};
    wire [7:0] swap_b  = {mem_i[3:0], mem_i[7:4]};            // Nibble exchange
    wire [7:0] bit_msk = mxt_pkg::ONE_BYTE << bit_sel_i;      // Bit select mask
    wire       bit_val = mem_i[bit_sel_i];                    // Tested bit

    // Flag values; only the mask decides which ones land
    assign flags_o[mxt_pkg::FLAG_CARRY] = ~diff9[8];  // RULE_12
    assign flags_o[mxt_pkg::FLAG_HALF]  = ~half5[4];  // RULE_13
    assign flags_o[mxt_pkg::FLAG_NULL]  = (res_o == mxt_pkg::ZERO_BYTE);
    assign flags_o[mxt_pkg::FLAG_RANGE] = (acc_i[7] ^ opnd[7]) & (diff9[7] ^ acc_i[7]);

    // ****************************************************************
    // Per-operation selection
    // ****************************************************************
    always_comb begin
        res_o      = mxt_pkg::ZERO_BYTE;
        acc_we_o   = 1'b0;
        mem_we_o   = 1'b0;
        flags_we_o = mxt_pkg::FLAGS_NONE;
        skip_o     = 1'b0;
        table_o    = 1'b0;
        case (op_i)
            mxt_pkg::OP_DEC_SKIP_TO_ACCUM: begin
                res_o    = dec_b;  // RULE_01
                acc_we_o = 1'b1;
                skip_o   = (dec_b == mxt_pkg::ZERO_BYTE);
            end
            mxt_pkg::OP_BYTE_SET: begin
                res_o    = mxt_pkg::ALL_ONES;  // RULE_02
                mem_we_o = 1'b1;
            end
            mxt_pkg::OP_BIT_SET: begin
                res_o    = mem_i | bit_msk;  // RULE_03
                mem_we_o = 1'b1;
            end
            mxt_pkg::OP_INC_SKIP_IN_MEMORY: begin
                res_o    = inc_b;  // RULE_04
                mem_we_o = 1'b1;
                skip_o   = (inc_b == mxt_pkg::ZERO_BYTE);
            end
            mxt_pkg::OP_INC_SKIP_TO_ACCUM: begin
                res_o    = inc_b;  // RULE_05
                acc_we_o = 1'b1;
                skip_o   = (inc_b == mxt_pkg::ZERO_BYTE);
            end
            mxt_pkg::OP_SKIP_IF_BIT_ONE:   skip_o = bit_val;   // RULE_07
            mxt_pkg::OP_SKIP_IF_BIT_CLEAR: skip_o = ~bit_val;  // RULE_08
            mxt_pkg::OP_SKIP_IF_NULL: begin
                skip_o = (mem_i == mxt_pkg::ZERO_BYTE);  // RULE_09
            end
            mxt_pkg::OP_COPY_AND_SKIP_IF_NULL: begin
                res_o    = mem_i;  // RULE_10
                acc_we_o = 1'b1;
                skip_o   = (mem_i == mxt_pkg::ZERO_BYTE);
            end
            mxt_pkg::OP_SUB_TO_ACCUM, mxt_pkg::OP_SUB_IMM: begin
                res_o      = diff9[7:0];  // RULE_11
                acc_we_o   = 1'b1;
                flags_we_o = mxt_pkg::FLAGS_SUB;  // RULE_13
            end
            mxt_pkg::OP_SUBTRACT_INTO_MEMORY: begin
                res_o      = diff9[7:0];  // RULE_11
                mem_we_o   = 1'b1;
                flags_we_o = mxt_pkg::FLAGS_SUB;  // RULE_13
            end
            mxt_pkg::OP_NIBBLE_EXCHANGE: begin
                res_o    = swap_b;  // RULE_14
                mem_we_o = 1'b1;
            end
            mxt_pkg::OP_NIBBLE_EXCHANGE_TO_ACCUM: begin
                res_o    = swap_b;  // RULE_15
                acc_we_o = 1'b1;
            end
            mxt_pkg::OP_TABLE_FETCH, mxt_pkg::OP_TABLE_FETCH_LAST_PAGE: begin
                table_o = 1'b1;
            end
            mxt_pkg::OP_XOR_TO_ACCUM, mxt_pkg::OP_XOR_IMM: begin
                res_o      = acc_i ^ opnd;  // RULE_18 RULE_20
                acc_we_o   = 1'b1;
                flags_we_o = mxt_pkg::FLAGS_NULL;
            end
            mxt_pkg::OP_EXCLUSIVE_OR_INTO_MEMORY: begin
                res_o      = acc_i ^ mem_i;  // RULE_19
                mem_we_o   = 1'b1;
                flags_we_o = mxt_pkg::FLAGS_NULL;
            end
            default: begin
                res_o = mxt_pkg::ZERO_BYTE;
            end
        endcase
    end

endmodule

//--- verilog/mxt_exec.sv
/*
 * Execute tail of the core: runs skip, set, subtract, swap, table read
 * and exclusive-OR operations, inserts the dummy cycle after a skip,
 * and holds the table high latch.
 * Assumes the addressed byte, accumulator and immediate are valid with
 * start_i, and that program memory returns data one cycle after rom_re_o.
 */
// How it works
// [RULE_01] Decrement to accumulator, skip on zero
// [RULE_02] Byte set writes all ones, no flags
// [RULE_03] Bit set forces one bit only
// [RULE_04] Increment in memory, skip on zero
// [RULE_05] Increment to accumulator, skip on zero
// [RULE_06] Taken skip inserts one dummy cycle
// [RULE_07] Skip when selected bit is one
// [RULE_08] Skip when selected bit is zero
// [RULE_09] Skip when whole byte is zero
// [RULE_10] Copy to accumulator, skip on zero
// [RULE_11] Three subtraction forms supported
// [RULE_12] Carry cleared on negative, else set
// [RULE_13] Subtraction updates four flags
// [RULE_14] Nibble swap written back to memory
// [RULE_15] Nibble swap placed in accumulator
// [RULE_16] Table read via high and low pointers
// [RULE_17] Last-page table read via low pointer
// [RULE_18] XOR with memory into accumulator, null flag
// [RULE_19] XOR written into memory, null flag
// [RULE_20] XOR with immediate into accumulator
// [RULE_21] Untaken skip finishes in one cycle
module mxt_exec #(
    parameter int unsigned PROM_AW = 12,  // Program address width
    parameter int unsigned PROM_DW = 16   // Program word width
) (
    input  wire logic                 clk_sys_i,           // Core clock
    input  wire logic                 rst_n_i,             // Async reset
    input  wire logic                 start_i,             // Issue operation
    input  wire mxt_pkg::mxt_op_t     op_i,                // Decoded operation
    input  wire logic [7:0]           acc_i,               // Accumulator
    input  wire logic [7:0]           mem_rdata_i,         // Addressed byte
    input  wire logic [7:0]           imm_i,               // Immediate operand
    input  wire logic [2:0]           bit_sel_i,           // Selected bit
    input  wire logic [7:0]           table_pointer_low_i, // Low pointer
    input  wire logic [PROM_AW-9:0]   table_pointer_high_i,// High pointer
    input  wire logic [PROM_DW-1:0]   rom_data_i,          // Program word
    output logic                      ready_o,             // Can take op
    output logic                      acc_we_o,            // Accumulator write
    output logic      [7:0]           acc_wdata_o,         // Accumulator data
    output logic                      mem_we_o,            // Memory write
    output logic      [7:0]           mem_wdata_o,         // Memory data
    output logic      [3:0]           flags_we_o,          // Flag write mask
    output logic      [3:0]           flags_o,             // Flag values
    output logic                      skip_o,              // Skip taken
    output logic                      dummy_o,             // Dummy cycle
    output logic                      done_o,              // Operation done
    output logic                      rom_re_o,            // Program read
    output logic      [PROM_AW-1:0]   rom_addr_o,          // Program address
    output logic      [PROM_DW-9:0]   table_high_latch_o   // Table high latch
);

    // ****************************************************************
    // Datapath
    // ****************************************************************
    logic [7:0] alu_res;      // Result byte
    logic       alu_acc_we;   // Goes to accumulator
    logic       alu_mem_we;   // Goes to memory
    logic [3:0] alu_fwe;      // Flag mask
    logic [3:0] alu_flags;    // Flag values
    logic       alu_skip;     // Skip condition
    logic       alu_table;    // Table read op

    mxt_alu u_alu (
        .op_i       (op_i),
        .acc_i      (acc_i),
        .mem_i      (mem_rdata_i),
        .imm_i      (imm_i),
        .bit_sel_i  (bit_sel_i),
        .res_o      (alu_res),
        .acc_we_o   (alu_acc_we),
        .mem_we_o   (alu_mem_we),
        .flags_we_o (alu_fwe),
        .flags_o    (alu_flags),
        .skip_o     (alu_skip),
        .table_o    (alu_table)
    );

    // ****************************************************************
    // Sequencer decode
    // ****************************************************************
    mxt_pkg::mxt_state_t st_q;    // Sequencer state
    mxt_pkg::mxt_state_t st_d;    // Next state

    wire take     = start_i && ready_o;             // Operation accepted
    wire rom_land = (st_q == mxt_pkg::ST_ROM_DATA); // Program word present
    wire last_pg  = (op_i == mxt_pkg::OP_TABLE_FETCH_LAST_PAGE);

    // Last page uses an all-ones upper field, normal read the high pointer
    wire [PROM_AW-9:0]  page_sel = last_pg ? {(PROM_AW-8){1'b1}}  // RULE_17
                                           : table_pointer_high_i; // RULE_16
    wire [PROM_AW-1:0]  rom_addr_d = {page_sel, table_pointer_low_i};

    // Next values of the write strobes and data
    wire        acc_we_d    = take && alu_acc_we;
    wire        mem_we_d    = (take && alu_mem_we) || rom_land;
    wire [7:0]  mem_wdata_d = rom_land ? rom_data_i[7:0] : alu_res; // RULE_16
    wire [3:0]  fwe_d       = take ? alu_fwe : mxt_pkg::FLAGS_NONE;
    wire        skip_d      = take && alu_skip;
    // A skip ends after its dummy cycle; an untaken one ends at once
    wire        done_d      = (take && !alu_skip && !alu_table)  // RULE_21
                              || (st_q == mxt_pkg::ST_DUMMY) || rom_land;

    assign ready_o  = (st_q == mxt_pkg::ST_IDLE);
    assign dummy_o  = (st_q == mxt_pkg::ST_DUMMY);    // RULE_06
    assign rom_re_o = (st_q == mxt_pkg::ST_ROM_REQ);

    // Next-state selection
    always_comb begin
        st_d = st_q;
        case (st_q)
            mxt_pkg::ST_IDLE: begin
                if (take && alu_table) begin
                    st_d = mxt_pkg::ST_ROM_REQ;
                end else if (take && alu_skip) begin
                    st_d = mxt_pkg::ST_DUMMY;  // RULE_06
                end
            end
            mxt_pkg::ST_ROM_REQ:  st_d = mxt_pkg::ST_ROM_DATA;
            mxt_pkg::ST_ROM_DATA: st_d = mxt_pkg::ST_IDLE;
            mxt_pkg::ST_DUMMY:    st_d = mxt_pkg::ST_IDLE;
            default:              st_d = mxt_pkg::ST_IDLE;
        endcase
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= mxt_pkg::ST_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************************************
    // Write strobes; pulses stand one cycle only
    // ****************************************************************
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_we_o   <= 1'b0;
            mem_we_o   <= 1'b0;
            flags_we_o <= mxt_pkg::FLAGS_NONE;
            skip_o     <= 1'b0;
            done_o     <= 1'b0;
        end else begin
            acc_we_o   <= acc_we_d;
            mem_we_o   <= mem_we_d;
            flags_we_o <= fwe_d;
            skip_o     <= skip_d;
            done_o     <= done_d;
        end
    end

    // ****************************************************************
    // Write data; held so a late consumer sees stable values
    // ****************************************************************
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_wdata_o <= mxt_pkg::ZERO_BYTE;
            mem_wdata_o <= mxt_pkg::ZERO_BYTE;
            flags_o     <= mxt_pkg::FLAGS_NONE;
        end else begin
            if (take) begin
                acc_wdata_o <= alu_res;
                flags_o     <= alu_flags;
            end
            if (mem_we_d) begin
                mem_wdata_o <= mem_wdata_d;
            end
        end
    end

    // ****************************************************************
    // Table address and high latch
    // ****************************************************************
    // Address is captured at accept, so pointers may move afterwards
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rom_addr_o         <= '0;
            table_high_latch_o <= '0;
        end else begin
            if (take && alu_table) begin
                rom_addr_o <= rom_addr_d;
            end
            if (rom_land) begin
                table_high_latch_o <= rom_data_i[PROM_DW-1:8]; // RULE_16 RULE_17
            end
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    // Second operand as the datapath sees it, for the flag check only
    wire [7:0] chk_opnd = (op_i == mxt_pkg::OP_SUB_IMM) ? imm_i : mem_rdata_i;
    wire       chk_sub  = take && (alu_fwe == mxt_pkg::FLAGS_SUB);

    AST_DEC_TO_ACCUM: assert property (  // RULE_01
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        take && op_i == mxt_pkg::OP_DEC_SKIP_TO_ACCUM |=>
        acc_we_o && !mem_we_o && acc_wdata_o == $past(mem_rdata_i) - 8'h01
        && skip_o == (acc_wdata_o == 8'h00))
        else $error("decrement to accumulator wrong");

    AST_BYTE_SET: assert property (  // RULE_02
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        take && op_i == mxt_pkg::OP_BYTE_SET |=>
        mem_we_o && mem_wdata_o == 8'hFF && flags_we_o == 4'h0)
        else $error("byte set wrong");

    AST_BIT_SET: assert property (  // RULE_03
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        take && op_i == mxt_pkg::OP_BIT_SET |=>
        mem_we_o && mem_wdata_o == ($past(mem_rdata_i) | (8'h01 << $past(bit_sel_i))))
        else $error("bit set wrong");

    AST_INC_IN_MEMORY: assert property (  // RULE_04
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        take && op_i == mxt_pkg::OP_INC_SKIP_IN_MEMORY |=>
        mem_we_o && !acc_we_o && mem_wdata_o == $past(mem_rdata_i) + 8'h01
        && skip_o == (mem_wdata_o == 8'h00))
        else $error("increment in memory wrong");

    AST_SKIP_DUMMY: assert property (  // RULE_06
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        skip_o |-> dummy_o && !done_o ##1 done_o && !dummy_o && ready_o)
        else $error("skip without one dummy cycle");

    AST_BIT_ONE: assert property (  // RULE_07
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        take && op_i == mxt_pkg::OP_SKIP_IF_BIT_ONE |=>
        skip_o == $past(mem_rdata_i[bit_sel_i]) && !mem_we_o && !acc_we_o)
        else $error("bit-one skip wrong");

    AST_BIT_CLEAR: assert property (  // RULE_08
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        take
        && op_i == mxt_pkg::OP_SKIP_IF_BIT_CLEAR
        |=> skip_o == !$past(mem_rdata_i[bit_sel_i])
        && dummy_o == skip_o
        && !mem_we_o && !acc_we_o)
        else $error("bit-clear skip wrong");

    AST_NO_SKIP_ONE_CYCLE: assert property (  // RULE_21
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        take && !alu_skip && !alu_table |=> done_o && !dummy_o && ready_o)
        else $error("untaken skip took extra cycle");

    AST_SUB_CARRY: assert property (  // RULE_12
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        chk_sub |=> flags_we_o == 4'hF
        && flags_o[mxt_pkg::FLAG_CARRY] == ($past(acc_i) >= $past(chk_opnd)))
        else $error("carry after subtract wrong");

    AST_SWAP_MEM: assert property (  // RULE_14
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        take && op_i == mxt_pkg::OP_NIBBLE_EXCHANGE |=>
        mem_we_o && mem_wdata_o == {$past(mem_rdata_i[3:0]), $past(mem_rdata_i[7:4])})
        else $error("nibble swap wrong");

    AST_TABLE_READ: assert property (  // RULE_16
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        take && alu_table |=> rom_re_o ##1 !rom_re_o ##1
        mem_we_o && done_o && mem_wdata_o == $past(rom_data_i[7:0]))
        else $error("table read sequence wrong");

    AST_LAST_PAGE: assert property (  // RULE_17
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        take && last_pg
        |=> rom_re_o
        && !ready_o
        && &rom_addr_o[PROM_AW-1:8])
        else $error("last page wrong");

    AST_XOR_NULL: assert property (  // RULE_19
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        take && op_i == mxt_pkg::OP_EXCLUSIVE_OR_INTO_MEMORY |=>
        mem_we_o && flags_we_o == 4'h4
        && flags_o[mxt_pkg::FLAG_NULL] == (mem_wdata_o == 8'h00)
        && mem_wdata_o == ($past(acc_i) ^ $past(mem_rdata_i)))
        else $error("xor into memory wrong");

    COV_SKIP_TAKEN:  cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        skip_o ##1 done_o);
    COV_SUB_NEG:     cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        flags_we_o == 4'hF && !flags_o[0]);
    COV_TABLE_LAST:  cover property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        take && last_pg ##3 done_o);

endmodule

//--- verilog/mxt_pkg.sv
/*
 * Shared constants and types for the instruction execute tail: operation
 * codes, sequencer states, flag positions, masks and reset values.
 * Assumes the fetch stage decodes opcodes into mxt_op_t.
 */
package mxt_pkg;

    // ****************************************************************
    // Data constants
    // ****************************************************************
    localparam logic [7:0] ZERO_BYTE     = 8'h00;  // Null result
    localparam logic [7:0] ONE_BYTE      = 8'h01;  // Step of inc/dec
    localparam logic [7:0] ALL_ONES      = 8'hFF;  // Byte-set value
    localparam logic [7:0] TBL_HIGH_RST  = 8'h00;  // High latch at reset

    // ****************************************************************
    // Flag positions and write masks
    // ****************************************************************
    localparam int unsigned FLAG_N       = 4;      // Flags handled here
    localparam int unsigned FLAG_CARRY   = 0;      // Arithmetic out bit
    localparam int unsigned FLAG_HALF    = 1;      // Half carry flag
    localparam int unsigned FLAG_NULL    = 2;      // Result null flag
    localparam int unsigned FLAG_RANGE   = 3;      // Signed range flag
    localparam logic [3:0]  FLAGS_NONE   = 4'h0;   // No flag touched
    localparam logic [3:0]  FLAGS_NULL   = 4'h4;   // Null flag only
    localparam logic [3:0]  FLAGS_SUB    = 4'hF;   // All four flags

    // ****************************************************************
    // Operations and sequencer states
    // ****************************************************************
    typedef enum logic [4:0] {
        OP_DEC_SKIP_TO_ACCUM,
        OP_BYTE_SET,
        OP_BIT_SET,
        OP_INC_SKIP_IN_MEMORY,
        OP_INC_SKIP_TO_ACCUM,
        OP_SKIP_IF_BIT_ONE,
        OP_SKIP_IF_BIT_CLEAR,
        OP_SKIP_IF_NULL,
        OP_COPY_AND_SKIP_IF_NULL,
        OP_SUB_TO_ACCUM,
        OP_SUBTRACT_INTO_MEMORY,
        OP_SUB_IMM,
        OP_NIBBLE_EXCHANGE,
        OP_NIBBLE_EXCHANGE_TO_ACCUM,
        OP_TABLE_FETCH,
        OP_TABLE_FETCH_LAST_PAGE,
        OP_XOR_TO_ACCUM,
        OP_EXCLUSIVE_OR_INTO_MEMORY,
        OP_XOR_IMM
    } mxt_op_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ROM_REQ,
        ST_ROM_DATA,
        ST_DUMMY
    } mxt_state_t;

endpackage
